//--- logic/synth_pa_pkg.sv
package synth_pa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_BASE_WORD_HIGH = 8'h00; // Base word bits 23:16
  localparam logic [7:0] OFS_BASE_WORD_MID = 8'h04; // Base word bits 15:8
  localparam logic [7:0] OFS_BASE_WORD_LOW = 8'h08; // Base word bits 7:0
  localparam logic [7:0] OFS_SLOT_INDEX_REG = 8'h0c; // Channel slot index
  localparam logic [7:0] OFS_MODEM_CFG_LOW = 8'h10; // Spacing mantissa
  localparam logic [7:0] OFS_MODEM_CFG_HIGH = 8'h14; // Spacing exponent
  localparam logic [7:0] OFS_SYNTH_CTRL_ONE = 8'h18; // Intermediate tune value
  localparam logic [7:0] OFS_STATE_MACHINE_CFG_ZERO = 8'h1c; // Auto calibrate mode
  localparam logic [7:0] OFS_PIN_OUTPUT_CFG = 8'h20; // Pin signal select
  localparam logic [7:0] OFS_SYNTH_CAL_RESULT_ONE = 8'h24; // Calibration result, read only
  localparam logic [7:0] OFS_FRONT_END_CFG_ZERO = 8'h28; // Power index limit, ASK enable
  localparam logic [7:0] OFS_TABLE_SINGLE = 8'h2c; // Table write, entry 0 only
  localparam logic [7:0] OFS_TABLE_BURST = 8'h30; // Table write, auto increment
  localparam logic [7:0] OFS_COMMAND = 8'h34; // Command strobes, write only
  localparam logic [7:0] OFS_STATUS = 8'h38; // Radio status, read only
  localparam logic [7:0] OFS_CARRIER_WORD = 8'h3c; // Computed tuning word, read only

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CMD_CALIBRATE_BIT = 0; // Calibrate strobe
  localparam int CMD_GO_TX_BIT = 1; // Enter transmit
  localparam int CMD_GO_RX_BIT = 2; // Enter receive
  localparam int CMD_GO_IDLE_BIT = 3; // Return to idle
  localparam int FE_ASK_ENABLE_BIT = 4; // ASK shaping enable in front end cfg

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [7:0] RST_BYTE = 8'h00; // Tuning bytes after reset
  localparam logic [4:0] RST_IF_VALUE = 5'h0f; // Intermediate tune value
  localparam logic [1:0] RST_AUTOCAL = 2'h0; // Calibrate manually
  localparam logic [5:0] RST_PIN_SELECT = 6'h00; // Pin driven low
  localparam logic [2:0] RST_POWER_LIMIT = 3'h0; // No ramping
  localparam logic [7:0] RST_LEVEL_ENTRY = 8'hc6; // Unwritten table entry
  localparam logic [5:0] CAL_RESULT_UNLOCKED = 6'h3f; // Means no lock
  localparam logic [5:0] CAL_RESULT_ALT = 6'h3e; // Locked code clipped off unlock value
  localparam logic [5:0] SEL_PLL_LOCK = 6'h0a; // Pin shows lock detector
  localparam logic [8:0] SPACING_OFFSET = 9'h100; // Added to spacing mantissa

  ////////////////////////////////////////////////////////////////////////////
  // Auto calibrate modes
  localparam logic [1:0] AUTOCAL_NEVER = 2'h0; // Only on strobe
  localparam logic [1:0] AUTOCAL_ON_START = 2'h1; // When synthesizer turns on
  localparam logic [1:0] AUTOCAL_ON_STOP = 2'h2; // When synthesizer turns off

  ////////////////////////////////////////////////////////////////////////////
  // Timing: calibration length in crystal periods, one hclk each
  localparam int CAL_CRYSTAL_OSC_PERIODS = 18739;

  ////////////////////////////////////////////////////////////////////////////
  // Radio states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CAL = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b011,
    ST_RAMP_DOWN = 3'b100
  } radio_state_t;

endpackage

//--- logic/level_table.sv
`timescale 1ns/1ps
// Output level table with reset defaults and registered read
module level_table
  import synth_pa_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem_q [DEPTH]; // Table entries

  ////////////////////////////////////////////////////////////////////////////
  // Entries start at the default level until written
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem_q[gi] <= WIDTH'(RST_LEVEL_ENTRY);
        end else if (wr_en && (wr_addr == gi)) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read of the selected entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_q <= WIDTH'(RST_LEVEL_ENTRY);
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule

//--- logic/synth_pa_ctrl.sv
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Spacing comes from mantissa and exponent fields
// - Base word is three bytes, 24 bits
// - 8-bit slot index times channel step
// - Word is base plus slot times scaled spacing
// - IF output follows programmed intermediate value
// - Auto calibrate on synthesizer start or stop
// - Calibrate strobe in idle starts calibration
// - Calibration lasts 18739 clock periods
// - Calibration result survives sleep
// - Select 0x0A puts lock on pin
// - Result other than 0x3F means lock
// - Eight entries, 3-bit limit selects entry
// - Ramp steps entries zero up to limit
// - Limit zero disables ramping, entry zero used
// - Unwritten entry reads default 0xC6
// - ASK counter up on one, down on zero
// - ASK counter saturates, indexes the table
module synth_pa_ctrl
  import synth_pa_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CRYSTAL_OSC_PERIODS, // Calibration length in cycles
  parameter int IF_WIDTH = 5 // Intermediate tune value width
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Synthesizer side
  input wire logic pll_lock_pin,
  input wire logic [5:0] vco_cal_code,
  output logic [24:0] carrier_word,
  output logic [IF_WIDTH-1:0] if_word,
  output logic synth_on,
  output logic cal_busy,
  output logic general_output_pin,
  // Modulator side
  input wire logic tx_bit,
  input wire logic shape_tick,
  output logic [7:0] pa_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] base_word_high_q, base_word_mid_q, base_word_low_q; // Base bytes
  logic [7:0] slot_index_q; // Channel slot
  logic [7:0] spacing_mantissa_q; // Spacing mantissa
  logic [1:0] spacing_exponent_q; // Spacing exponent
  logic [IF_WIDTH-1:0] intermediate_tune_value_q; // IF value
  logic [1:0] auto_calibrate_mode_q; // Calibration trigger mode
  logic [5:0] pin_signal_select_q; // Pin source select
  logic [2:0] power_index_limit_q; // Highest table index
  logic ask_enable_q; // ASK shaping on
  logic [2:0] burst_ptr_q; // Next burst entry
  logic [5:0] cal_result_q; // Calibration result

  // Bus pipeline
  logic wr_pend_q; // Write data phase pending
  logic [7:0] wr_addr_q; // Captured write offset
  logic hreadyout_q, hresp_q; // Response flops
  logic [31:0] hrdata_q; // Read data flop

  // Radio control
  radio_state_t state_q, state_d; // Radio state
  radio_state_t cal_ret_q, cal_ret_d; // State after calibration
  logic [14:0] cal_cnt_q; // Calibration cycle count
  logic [2:0] lock_sync_q; // Lock pin synchroniser
  logic lock_q; // Filtered lock level
  logic [2:0] level_idx_q; // Table index in use
  logic [24:0] carrier_word_q; // Registered tuning word
  logic [IF_WIDTH-1:0] if_word_q; // Registered IF value
  logic gpo_q; // General output pin flop
  logic synth_on_q, cal_busy_q; // Status flops

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire addr_phase = hsel && htrans[1] && hready; // Valid address phase
  wire rd_req = addr_phase && !hwrite; // Read request
  wire wr_data = wr_pend_q; // Write data phase now
  wire [7:0] rd_ofs = {haddr[7:2], 2'b00}; // Aligned read offset

  // Register write strobe for one offset
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_data && (wr_addr_q == ofs);
  endfunction

  wire cmd_wr = hit(OFS_COMMAND); // Command write
  wire cal_strobe = cmd_wr && hwdata[CMD_CALIBRATE_BIT]; // Calibrate strobe
  wire go_tx = cmd_wr && hwdata[CMD_GO_TX_BIT]; // Enter transmit
  wire go_rx = cmd_wr && hwdata[CMD_GO_RX_BIT]; // Enter receive
  wire go_idle = cmd_wr && hwdata[CMD_GO_IDLE_BIT]; // Leave receive or transmit
  wire tbl_single = hit(OFS_TABLE_SINGLE); // Entry 0 write
  wire tbl_burst = hit(OFS_TABLE_BURST); // Pointer write
  wire tbl_wr = tbl_single || tbl_burst; // Any table write
  wire [2:0] tbl_addr = tbl_single ? 3'h0 : burst_ptr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Tuning word arithmetic
  wire [23:0] base_carrier_word = {base_word_high_q, base_word_mid_q, base_word_low_q};
  wire [8:0] spacing_step = SPACING_OFFSET + {1'b0, spacing_mantissa_q};
  wire [16:0] slot_product = slot_index_q * spacing_step;
  wire [19:0] slot_scaled = {3'b000, slot_product} << spacing_exponent_q;
  wire [26:0] word_quarter = {1'b0, base_carrier_word, 2'b00} + {7'h00, slot_scaled};
  wire cal_done = (state_q == ST_CAL) && (cal_cnt_q == 15'(CAL_CYCLES - 1));
  wire lock_change = (lock_sync_q[1] == lock_sync_q[2]); // Second and third agree

  ////////////////////////////////////////////////////////////////////////////
  // Register read multiplexer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_ofs)
      OFS_BASE_WORD_HIGH: rd_mux = {24'h0, base_word_high_q};
      OFS_BASE_WORD_MID: rd_mux = {24'h0, base_word_mid_q};
      OFS_BASE_WORD_LOW: rd_mux = {24'h0, base_word_low_q};
      OFS_SLOT_INDEX_REG: rd_mux = {24'h0, slot_index_q};
      OFS_MODEM_CFG_LOW: rd_mux = {24'h0, spacing_mantissa_q};
      OFS_MODEM_CFG_HIGH: rd_mux = {30'h0, spacing_exponent_q};
      OFS_SYNTH_CTRL_ONE: rd_mux = 32'(intermediate_tune_value_q);
      OFS_STATE_MACHINE_CFG_ZERO: rd_mux = {30'h0, auto_calibrate_mode_q};
      OFS_PIN_OUTPUT_CFG: rd_mux = {26'h0, pin_signal_select_q};
      OFS_SYNTH_CAL_RESULT_ONE: rd_mux = {26'h0, cal_result_q};
      OFS_FRONT_END_CFG_ZERO: rd_mux = {27'h0, ask_enable_q, 1'b0, power_index_limit_q};
      OFS_STATUS: rd_mux = {24'h0, level_idx_q, lock_q, cal_busy_q, state_q};
      OFS_CARRIER_WORD: rd_mux = {7'h0, carrier_word_q};
      default: rd_mux = 32'h0000_0000; // Unmapped and write-only read zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pipeline: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
      end
      if (rd_req) begin
        hrdata_q <= rd_mux;
      end
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_word_high_q <= RST_BYTE;
      base_word_mid_q <= RST_BYTE;
      base_word_low_q <= RST_BYTE;
      slot_index_q <= RST_BYTE;
      spacing_mantissa_q <= RST_BYTE;
      spacing_exponent_q <= 2'h0;
      intermediate_tune_value_q <= IF_WIDTH'(RST_IF_VALUE);
      auto_calibrate_mode_q <= RST_AUTOCAL;
      pin_signal_select_q <= RST_PIN_SELECT;
      power_index_limit_q <= RST_POWER_LIMIT;
      ask_enable_q <= 1'b0;
    end else begin
      if (hit(OFS_BASE_WORD_HIGH)) base_word_high_q <= hwdata[7:0];
      if (hit(OFS_BASE_WORD_MID)) base_word_mid_q <= hwdata[7:0];
      if (hit(OFS_BASE_WORD_LOW)) base_word_low_q <= hwdata[7:0];
      if (hit(OFS_SLOT_INDEX_REG)) slot_index_q <= hwdata[7:0];
      if (hit(OFS_MODEM_CFG_LOW)) spacing_mantissa_q <= hwdata[7:0];
      if (hit(OFS_MODEM_CFG_HIGH)) spacing_exponent_q <= hwdata[1:0];
      if (hit(OFS_SYNTH_CTRL_ONE)) intermediate_tune_value_q <= hwdata[IF_WIDTH-1:0];
      if (hit(OFS_STATE_MACHINE_CFG_ZERO)) auto_calibrate_mode_q <= hwdata[1:0];
      if (hit(OFS_PIN_OUTPUT_CFG)) pin_signal_select_q <= hwdata[5:0];
      if (hit(OFS_FRONT_END_CFG_ZERO)) begin
        power_index_limit_q <= hwdata[2:0];
        ask_enable_q <= hwdata[FE_ASK_ENABLE_BIT];
      end
    end
  end

  // Burst pointer: single write restarts it at entry 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_ptr_q <= 3'h0;
    end else if (tbl_single) begin
      burst_ptr_q <= 3'h1;
    end else if (tbl_burst) begin
      burst_ptr_q <= burst_ptr_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Radio state transitions
  always_comb begin
    state_d = state_q;
    cal_ret_d = cal_ret_q;
    case (state_q)
      ST_IDLE: begin
        if (cal_strobe) begin
          state_d = ST_CAL;
          cal_ret_d = ST_IDLE;
        end else if (go_tx || go_rx) begin
          cal_ret_d = go_tx ? ST_TX : ST_RX;
          // Calibrate first when set to calibrate on start
          state_d = (auto_calibrate_mode_q == AUTOCAL_ON_START) ? ST_CAL : cal_ret_d;
        end
      end
      ST_CAL: begin
        if (cal_done) begin
          state_d = cal_ret_q;
        end
      end
      ST_RX: begin
        if (go_idle) begin
          cal_ret_d = ST_IDLE;
          state_d = (auto_calibrate_mode_q == AUTOCAL_ON_STOP) ? ST_CAL : ST_IDLE;
        end
      end
      ST_TX: begin
        if (go_idle) begin
          state_d = ST_RAMP_DOWN;
        end
      end
      ST_RAMP_DOWN: begin
        // Finished once the index is back at entry zero
        if (level_idx_q == 3'h0) begin
          cal_ret_d = ST_IDLE;
          state_d = (auto_calibrate_mode_q == AUTOCAL_ON_STOP) ? ST_CAL : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State and calibration counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      cal_ret_q <= ST_IDLE;
      cal_cnt_q <= 15'h0000;
    end else begin
      state_q <= state_d;
      cal_ret_q <= cal_ret_d;
      cal_cnt_q <= (state_q == ST_CAL && !cal_done) ? cal_cnt_q + 15'h0001 : 15'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock pin: three flops, level taken when second and third agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_sync_q <= 3'b000;
      lock_q <= 1'b0;
    end else begin
      lock_sync_q <= {lock_sync_q[1:0], pll_lock_pin};
      if (lock_change) begin
        lock_q <= lock_sync_q[2];
      end
    end
  end

  // Result kept until the next calibration; only reset clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_result_q <= CAL_RESULT_UNLOCKED;
    end else if (cal_done) begin
      if (!lock_q) begin
        cal_result_q <= CAL_RESULT_UNLOCKED;
      end else if (vco_cal_code == CAL_RESULT_UNLOCKED) begin
        cal_result_q <= CAL_RESULT_ALT;
      end else begin
        cal_result_q <= vco_cal_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table index: ramp or ASK shaping, both stepped by shape_tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_idx_q <= 3'h0;
    end else if (state_q != ST_TX && state_q != ST_RAMP_DOWN) begin
      level_idx_q <= 3'h0;
    end else if (shape_tick) begin
      if (state_q == ST_RAMP_DOWN) begin
        if (level_idx_q != 3'h0) level_idx_q <= level_idx_q - 3'h1;
      end else if (ask_enable_q && !tx_bit) begin
        if (level_idx_q != 3'h0) level_idx_q <= level_idx_q - 3'h1;
      end else if (level_idx_q < power_index_limit_q) begin
        level_idx_q <= level_idx_q + 3'h1;
      end else begin
        level_idx_q <= power_index_limit_q;
      end
    end
  end

  // Output level table
  level_table #(
    .DEPTH(8),
    .WIDTH(8)
  ) u_table (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(tbl_wr),
    .wr_addr(tbl_addr),
    .wr_data(hwdata[7:0]),
    .rd_addr(level_idx_q),
    .rd_data_q(pa_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer-facing output flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carrier_word_q <= 25'h0;
      if_word_q <= IF_WIDTH'(RST_IF_VALUE); // Matches the IF register after reset
      gpo_q <= 1'b0;
      synth_on_q <= 1'b0;
      cal_busy_q <= 1'b0;
    end else begin
      carrier_word_q <= word_quarter[26:2];
      if_word_q <= intermediate_tune_value_q;
      gpo_q <= (pin_signal_select_q == SEL_PLL_LOCK) && lock_q;
      synth_on_q <= (state_d != ST_IDLE);
      cal_busy_q <= (state_d == ST_CAL);
    end
  end

  // Ports driven straight from flops
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign carrier_word = carrier_word_q;
  assign if_word = if_word_q;
  assign general_output_pin = gpo_q;
  assign synth_on = synth_on_q;
  assign cal_busy = cal_busy_q;

endmodule

//--- testbench/synth_pa_ctrl_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port-level watcher for the synth and PA level block
module synth_pa_ctrl_chk
  import synth_pa_pkg::*;
#(
  parameter int CAL_CYCLES = 20,
  parameter int IF_WIDTH = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Synthesizer side
  input wire logic pll_lock_pin,
  input wire logic [24:0] carrier_word,
  input wire logic [IF_WIDTH-1:0] if_word,
  input wire logic synth_on,
  input wire logic cal_busy,
  input wire logic general_output_pin
);
  logic wdp_q; // Write data phase in progress
  int cal_cnt_q; // Cycles spent calibrating

  ////////////////////////////////////////////////////////////////////////////////
  // Helper state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdp_q <= 1'b0;
      cal_cnt_q <= 0;
    end else begin
      wdp_q <= hsel && htrans[1] && hready && hwrite;
      cal_cnt_q <= cal_busy ? cal_cnt_q + 1 : 0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus stalled or error response");
  property p_rdata_hold;
    !$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  property p_cal_len;
    $fell(cal_busy) |-> cal_cnt_q == CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration length wrong");
  property p_cal_bound;
    cal_cnt_q <= CAL_CYCLES;
  endproperty
  a_cal_bound: assert property (p_cal_bound)
    else $error("calibration overran");
  property p_cal_on;
    cal_busy |-> synth_on;
  endproperty
  a_cal_on: assert property (p_cal_on)
    else $error("calibrating with synthesizer off");
  property p_carrier_hold;
    !$past(wdp_q, 2) |-> $stable(carrier_word);
  endproperty
  a_carrier_hold: assert property (p_carrier_hold)
    else $error("carrier word changed without a write");
  property p_if_hold;
    !$past(wdp_q, 2) |-> $stable(if_word);
  endproperty
  a_if_hold: assert property (p_if_hold)
    else $error("IF word changed without a write");
  property p_pin_unlocked;
    !pll_lock_pin [*8] |-> !general_output_pin;
  endproperty
  a_pin_unlocked: assert property (p_pin_unlocked)
    else $error("pin high while PLL unlocked");
endmodule

bind synth_pa_ctrl synth_pa_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES), .IF_WIDTH(IF_WIDTH)) i_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .pll_lock_pin, .carrier_word, .if_word, .synth_on, .cal_busy, .general_output_pin);

//--- testbench/testbench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the synth and PA level block
module testbench;
  import synth_pa_pkg::*;
  localparam int CALN = 20; // Shortened calibration
  // Bus and control signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pll_lock_pin, synth_on, cal_busy, general_output_pin, tx_bit, shape_tick;
  logic [5:0] vco_cal_code;
  logic [24:0] carrier_word, exp_cw;
  logic [4:0] if_word;
  logic [7:0] pa_level;
  logic [7:0] tbl [8]; // Expected table contents
  int fails, tests_run, idx, n;

  assign hready = hreadyout; // Single slave on the bus
  synth_pa_ctrl #(.CAL_CYCLES(CALN)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pll_lock_pin, .vco_cal_code,
    .carrier_word, .if_word, .synth_on, .cal_busy, .general_output_pin, .tx_bit,
    .shape_tick, .pa_level);

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // One single AHB transfer, waits on hready in both phases
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  // Count calibration cycles, zero if none starts soon
  task automatic wcal(output int c);
    c = 0;
    for (int i = 0; i < 5 && cal_busy !== 1'b1; i++) @(posedge hclk);
    while (cal_busy === 1'b1) begin
      @(posedge hclk);
      c++;
    end
  endtask
  // One shaping tick, then compare level against expected index
  task automatic tick(input int lim, input logic up);
    idx = up ? (idx < lim ? idx + 1 : idx) : (idx > 0 ? idx - 1 : 0);
    @(posedge hclk);
    tx_bit <= up;
    shape_tick <= 1'b1;
    @(posedge hclk);
    shape_tick <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("pa_level", {24'h0, tbl[idx]}, {24'h0, pa_level});
  endtask
  task automatic results;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, tx_bit, shape_tick, pll_lock_pin} = '0;
    hsize = 3'b010;
    vco_cal_code = 6'h15;
    {fails, tests_run, idx} = '0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk("if_word", 32'h0f, {27'h0, if_word});
    chk("pa_level", 32'hc6, {24'h0, pa_level});
    bus(OFS_SYNTH_CAL_RESULT_ONE, 1'b0, 0);
    chk("cal result", 32'h3f, rv);
    bus(8'hfc, 1'b0, 0);
    chk("unmapped", 32'h0, rv);
    // Tuning word for every exponent
    wr(OFS_BASE_WORD_HIGH, 32'hab);
    wr(OFS_BASE_WORD_MID, 32'hcd);
    wr(OFS_BASE_WORD_LOW, 32'hef);
    wr(OFS_SLOT_INDEX_REG, 32'hff);
    wr(OFS_MODEM_CFG_LOW, 32'h5a);
    for (int e = 0; e < 4; e++) begin
      wr(OFS_MODEM_CFG_HIGH, 32'(e));
      exp_cw = 25'((64'habcdef * 4 + ((64'hff * (64'd256 + 64'h5a)) << e)) / 4);
      bus(OFS_CARRIER_WORD, 1'b0, 0);
      chk("carrier reg", {7'h0, exp_cw}, rv);
      chk("carrier_word", {7'h0, exp_cw}, {7'h0, carrier_word});
    end
    wr(OFS_SYNTH_CTRL_ONE, 32'h15);
    repeat (2) @(posedge hclk);
    chk("if_word", 32'h15, {27'h0, if_word});
    // Manual calibration with and without lock
    pll_lock_pin <= 1'b1;
    vco_cal_code <= 6'h3f;
    wr(OFS_PIN_OUTPUT_CFG, 32'h0a);
    wr(OFS_COMMAND, 32'h1);
    wcal(n);
    chk("cal cycles", CALN, n);
    bus(OFS_SYNTH_CAL_RESULT_ONE, 1'b0, 0);
    chk("cal result", 32'h3e, rv);
    chk("lock pin", 32'h1, {31'h0, general_output_pin});
    wr(OFS_PIN_OUTPUT_CFG, 32'h0);
    repeat (2) @(posedge hclk);
    chk("lock pin", 32'h0, {31'h0, general_output_pin});
    pll_lock_pin <= 1'b0;
    vco_cal_code <= 6'h15;
    repeat (8) @(posedge hclk);
    wr(OFS_COMMAND, 32'h1);
    wcal(n);
    bus(OFS_SYNTH_CAL_RESULT_ONE, 1'b0, 0);
    chk("cal result", 32'h3f, rv);
    pll_lock_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    wr(OFS_COMMAND, 32'h1);
    wcal(n);
    bus(OFS_SYNTH_CAL_RESULT_ONE, 1'b0, 0);
    chk("cal result", 32'h15, rv);
    // Strobe outside idle is ignored
    wr(OFS_COMMAND, 32'h4);
    wr(OFS_COMMAND, 32'h1);
    wcal(n);
    chk("cal in rx", 0, n);
    chk("synth_on", 32'h1, {31'h0, synth_on});
    wr(OFS_COMMAND, 32'h8);
    // Automatic calibration modes
    for (int m = 1; m < 3; m++) begin
      wr(OFS_STATE_MACHINE_CFG_ZERO, 32'(m));
      wr(OFS_COMMAND, 32'h4);
      wcal(n);
      chk("cal on start", m == 1 ? CALN : 0, n);
      wr(OFS_COMMAND, 32'h8);
      wcal(n);
      chk("cal on stop", m == 2 ? CALN : 0, n);
    end
    wr(OFS_STATE_MACHINE_CFG_ZERO, 32'h0);
    // Table fill, ASK shaping and ramping
    tbl[0] = 8'h11;
    wr(OFS_TABLE_SINGLE, 32'h11);
    for (int i = 1; i < 8; i++) begin
      tbl[i] = 8'h20 + 8'(i);
      wr(OFS_TABLE_BURST, {24'h0, tbl[i]});
    end
    wr(OFS_FRONT_END_CFG_ZERO, 32'h17);
    wr(OFS_COMMAND, 32'h2);
    repeat (9) tick(7, 1'b1);
    repeat (9) tick(7, 1'b0);
    repeat (3) tick(7, 1'b1);
    wr(OFS_COMMAND, 32'h8);
    repeat (3) tick(7, 1'b0);
    idx = 0;
    wr(OFS_COMMAND, 32'h2);
    repeat (3) @(posedge hclk);
    chk("pa_level", {24'h0, tbl[0]}, {24'h0, pa_level});
    repeat (3) tick(7, 1'b1);
    wr(OFS_COMMAND, 32'h8);
    bus(OFS_STATUS, 1'b0, 0);
    chk("status", 32'h64, rv & 32'hef);
    repeat (3) tick(7, 1'b0);
    repeat (3) @(posedge hclk);
    bus(OFS_STATUS, 1'b0, 0);
    chk("status", 32'h0, rv & 32'h7);
    wr(OFS_FRONT_END_CFG_ZERO, 32'h10);
    wr(OFS_COMMAND, 32'h2);
    repeat (2) tick(0, 1'b1);
    wr(OFS_COMMAND, 32'h8);
    results;
  end
endmodule
